// ==== logic/hsdma_regs.svh ====
// Register offsets, field positions and reset values of the
// handshake interrupt and DMA request sequencer.
// Assumes a 32-bit AXI4-Lite slave with byte addresses.
`ifndef HSDMA_REGS_SVH
`define HSDMA_REGS_SVH

// Byte offsets
`define CONFIG_REG_ONE_OFF    8'h00
`define CONFIG_REG_TWO_OFF    8'h04
`define CONFIG_REG_THREE_OFF    8'h08
`define STAT_OFF    8'h0c
`define TCCLR1_OFF  8'h10
`define TCCLR2_OFF  8'h14
`define TMRCLR_OFF  8'h18
`define DATA1_OFF   8'h1c
`define DATA2_OFF   8'h20

// Group config fields (config_reg_one and config_reg_two)
`define GC_IRQEN_BIT  0
`define GC_DREQEN_BIT 1
`define GC_GRST_BIT   2

// Mode config fields (config_reg_three)
`define M_TCEN1_BIT 0
`define M_TCEN2_BIT 1
`define M_TMREN_BIT 2
`define M_PING_BIT  3
`define M_WIDE_BIT  4

// Reset values and responses
`define GC_RST    2'h0
`define MODE_RST  5'h00
`define RESP_OKAY 2'h0
`define RESP_SERR 2'h2

`endif

// ==== logic/hsdma_pkg.sv ====
// Types of the handshake interrupt and DMA request sequencer.
// Assumes hsdma_regs.svh for the numeric layout.
package hsdma_pkg;

  // Per-group configuration
  typedef struct packed {
    logic dreq_enable;
    logic ready_irq_enable;
  } grp_cfg_t;

  // Mode configuration
  typedef struct packed {
    logic wide_word_mode;
    logic pingpong_channel_mode;
    logic timer_irq_enable;
    logic termcount_irq_enable_g2;
    logic termcount_irq_enable_g1;
  } mode_cfg_t;

  // Status word, bit 0 at the bottom
  typedef struct packed {
    logic acknowledge_out_g2;
    logic acknowledge_out_g1;
    logic active_channel_flag;
    logic timer_irq_flag;
    logic termcount_flag_g2;
    logic termcount_flag_g1;
    logic data_ready_g2;
    logic data_ready_g1;
  } stat_t;

endpackage : hsdma_pkg

// ==== logic/handshake_irq_dma_sequencer.sv ====
// Interrupt, DMA request and 32-bit pairing logic of a
// two-group handshaking digital I/O port.
// Assumes pins arrive asynchronously; AXI4-Lite on i_clk_sys.
// How it works
// - Group one ready raises interrupt when enabled
// - Group two ready raises interrupt when enabled
// - Status shows each group's ready flag
// - Data access clears that group's ready flag
// - Group one terminal count sets flag and interrupts, both only when enabled
// - Group two terminal count sets flag and interrupts, both only when enabled
// - Write clears group one terminal count flag
// - Write clears group two terminal count flag
// - Timer rising edge sets flag when enabled
// - Write clears timer flag and its interrupt
// - Timer interrupt shares group two line
// - Each group's DMA has own enable
// - Enabled DMA requests while ready flag set
// - Ping-pong uses group one lines, both channels
// - Ping-pong alternates channels at terminal count
// - Status bit shows active ping-pong channel
// - Wide request sets both ready; ignore group two
// - Wide acknowledge after both words transferred
// - Both group resets restart wide sequence
// - Wide DMA uses group one channel only, unless ping-pong alternates both channels
`include "hsdma_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module handshake_irq_dma_sequencer
  import hsdma_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              i_clk_sys,
  input  wire logic              i_nrst,
  input  wire logic              i_awvalid,
  output var  logic              o_awready,
  input  wire logic [ADDR_W-1:0] i_awaddr,
  input  wire logic              i_wvalid,
  output var  logic              o_wready,
  input  wire logic [31:0]       i_wdata,
  input  wire logic [3:0]        i_wstrb,
  output var  logic              o_bvalid,
  input  wire logic              i_bready,
  output var  logic [1:0]        o_bresp,
  input  wire logic              i_arvalid,
  output var  logic              o_arready,
  input  wire logic [ADDR_W-1:0] i_araddr,
  output var  logic              o_rvalid,
  input  wire logic              i_rready,
  output var  logic [31:0]       o_rdata,
  output var  logic [1:0]        o_rresp,
  input  wire logic              i_request_in_g1,
  input  wire logic              i_request_in_g2,
  input  wire logic [31:0]       i_port_in,
  output var  logic [31:0]       o_port_out,
  output var  logic              o_acknowledge_out_g1,
  output var  logic              o_acknowledge_out_g2,
  input  wire logic              i_timer_out,
  input  wire logic              i_dma_tc_g1,
  input  wire logic              i_dma_tc_g2,
  output var  logic              o_dreq_g1,
  output var  logic              o_dreq_g2,
  output var  logic              o_irq_g1,
  output var  logic              o_irq_g2
);

  // Elaboration check on the address width
  if (ADDR_W < 8) begin : g_addr_chk
    $error("ADDR_W must be at least 8");
  end

  // Word-aligned address match
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0] off);
    hit = (a[ADDR_W-1:2] == (ADDR_W-2)'(off[7:2]));
  endfunction : hit

  ////////////////////////////////////////////////////////////
  // Pin synchronisers: five control pins and 32 data lines
  logic [36:0] pin_s1_reg;
  logic [36:0] pin_s2_reg;
  logic [4:0]  pin_s3_reg;
  logic [4:0]  pin_rise;
  logic        request_in_g1_edge;
  logic        request_in_g2_edge;
  logic        tmr_edge;
  logic        tc1_edge;
  logic        tc2_edge;

  // Two stages, then a third for edge detection
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
      pin_s3_reg <= '0;
    end else begin
      pin_s1_reg <= {i_port_in, i_dma_tc_g2, i_dma_tc_g1,
                     i_timer_out, i_request_in_g2,
                     i_request_in_g1};
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg[4:0];
    end
  end

  // Rising edges of the synchronised pins
  assign pin_rise  = pin_s2_reg[4:0] & ~pin_s3_reg;
  assign request_in_g1_edge = pin_rise[0];
  assign request_in_g2_edge = pin_rise[1];
  assign tmr_edge  = pin_rise[2];
  assign tc1_edge  = pin_rise[3];
  assign tc2_edge  = pin_rise[4];

  ////////////////////////////////////////////////////////////
  // AXI4-Lite handshake state
  logic              aw_rdy_reg;
  logic              w_rdy_reg;
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;
  logic              ar_rdy_reg;
  logic              rvalid_reg;
  logic [31:0]       rdata_reg;
  logic [1:0]        rresp_reg;
  logic [ADDR_W-1:0] waddr_reg;
  logic [31:0]       wdata_reg;
  logic [3:0]        wstrb_reg;
  logic              aw_hs;
  logic              w_hs;
  logic              b_hs;
  logic              ar_hs;
  logic              r_hs;
  logic              wr_fire;

  // Channel transfers
  assign aw_hs   = i_awvalid & aw_rdy_reg;
  assign w_hs    = i_wvalid & w_rdy_reg;
  assign b_hs    = bvalid_reg & i_bready;
  assign ar_hs   = i_arvalid & ar_rdy_reg;
  assign r_hs    = rvalid_reg & i_rready;
  assign wr_fire = ~aw_rdy_reg & ~w_rdy_reg & ~bvalid_reg;

  // Write decode
  logic wr_config_reg_one;
  logic wr_config_reg_two;
  logic wr_config_reg_three;
  logic wr_tcclr1;
  logic wr_tcclr2;
  logic wr_tmrclr;
  logic wr_data1;
  logic wr_data2;
  logic wr_known;

  assign wr_config_reg_one   = wr_fire & hit(waddr_reg, `CONFIG_REG_ONE_OFF);
  assign wr_config_reg_two   = wr_fire & hit(waddr_reg, `CONFIG_REG_TWO_OFF);
  assign wr_config_reg_three   = wr_fire & hit(waddr_reg, `CONFIG_REG_THREE_OFF);
  assign wr_tcclr1 = wr_fire & hit(waddr_reg, `TCCLR1_OFF);
  assign wr_tcclr2 = wr_fire & hit(waddr_reg, `TCCLR2_OFF);
  assign wr_tmrclr = wr_fire & hit(waddr_reg, `TMRCLR_OFF);
  assign wr_data1  = wr_fire & hit(waddr_reg, `DATA1_OFF);
  assign wr_data2  = wr_fire & hit(waddr_reg, `DATA2_OFF);
  assign wr_known  = wr_config_reg_one | wr_config_reg_two | wr_config_reg_three | wr_tcclr1 |
                     wr_tcclr2 | wr_tmrclr | wr_data1 | wr_data2 |
                     hit(waddr_reg, `STAT_OFF);

  // Address and data capture; ready drops until the response
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      aw_rdy_reg <= 1'b1;
      w_rdy_reg  <= 1'b1;
      bvalid_reg <= 1'b0;
      bresp_reg  <= `RESP_OKAY;
      waddr_reg  <= '0;
      wdata_reg  <= '0;
      wstrb_reg  <= '0;
    end else begin
      if (aw_hs) begin
        aw_rdy_reg <= 1'b0;
        waddr_reg  <= i_awaddr;
      end else if (b_hs) begin
        aw_rdy_reg <= 1'b1;
      end
      if (w_hs) begin
        w_rdy_reg <= 1'b0;
        wdata_reg <= i_wdata;
        wstrb_reg <= i_wstrb;
      end else if (b_hs) begin
        w_rdy_reg <= 1'b1;
      end
      if (wr_fire) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= wr_known ? `RESP_OKAY : `RESP_SERR;
      end else if (b_hs) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // Read decode
  logic rd_data1;
  logic rd_data2;

  assign rd_data1 = ar_hs & hit(i_araddr, `DATA1_OFF);
  assign rd_data2 = ar_hs & hit(i_araddr, `DATA2_OFF);

  ////////////////////////////////////////////////////////////
  // Configuration registers
  grp_cfg_t  config_reg_one_reg;
  grp_cfg_t  config_reg_two_reg;
  mode_cfg_t mode_reg;
  logic [15:0] out1_reg;
  logic [15:0] out2_reg;
  logic [31:0] in_latch_reg;
  logic        grst1;
  logic        grst2;

  // Self-clearing group resets from the config write
  assign grst1 = wr_config_reg_one & wstrb_reg[0] & wdata_reg[`GC_GRST_BIT];
  assign grst2 = wr_config_reg_two & wstrb_reg[0] & wdata_reg[`GC_GRST_BIT];

  // Software-written control and output words
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      config_reg_one_reg <= `GC_RST;
      config_reg_two_reg <= `GC_RST;
      mode_reg <= `MODE_RST;
      out1_reg <= '0;
      out2_reg <= '0;
    end else begin
      if (wr_config_reg_one && wstrb_reg[0])
        config_reg_one_reg <= grp_cfg_t'(wdata_reg[1:0]);
      if (wr_config_reg_two && wstrb_reg[0])
        config_reg_two_reg <= grp_cfg_t'(wdata_reg[1:0]);
      if (wr_config_reg_three && wstrb_reg[0])
        mode_reg <= mode_cfg_t'(wdata_reg[4:0]);
      if (wr_data1)
        out1_reg <= wdata_reg[15:0];
      if (wr_data2)
        out2_reg <= wdata_reg[15:0];
    end
  end

  ////////////////////////////////////////////////////////////
  // Event flags; a set in the clearing cycle wins, except against both group resets and for the acknowledge flags
  stat_t st_reg;
  stat_t st_next;
  logic  wide;
  logic  ping;
  logic  acc1;
  logic  acc2;
  logic  rq1;
  logic  rq2;
  logic  act_tc;

  assign wide   = mode_reg.wide_word_mode;
  assign ping   = mode_reg.pingpong_channel_mode;
  assign acc1   = wr_data1 | rd_data1;
  assign acc2   = wr_data2 | rd_data2;
  assign rq1    = request_in_g1_edge;
  assign rq2    = wide ? request_in_g1_edge : request_in_g2_edge;
  assign act_tc = st_reg.active_channel_flag ? tc2_edge : tc1_edge;

  // Next status word
  always_comb begin
    st_next = st_reg;
    // Access clears ready, request sets it
    if (acc1 || grst1)
      st_next.data_ready_g1 = 1'b0;
    if (acc2 || grst2)
      st_next.data_ready_g2 = 1'b0;
    if (rq1)
      st_next.data_ready_g1 = 1'b1;
    if (rq2)
      st_next.data_ready_g2 = 1'b1;
    // Terminal count flags
    if (wr_tcclr1)
      st_next.termcount_flag_g1 = 1'b0;
    if (wr_tcclr2)
      st_next.termcount_flag_g2 = 1'b0;
    if (tc1_edge && mode_reg.termcount_irq_enable_g1)
      st_next.termcount_flag_g1 = 1'b1;
    if (tc2_edge && mode_reg.termcount_irq_enable_g2)
      st_next.termcount_flag_g2 = 1'b1;
    // Timer event flag
    if (wr_tmrclr)
      st_next.timer_irq_flag = 1'b0;
    if (tmr_edge && mode_reg.timer_irq_enable)
      st_next.timer_irq_flag = 1'b1;
    // Ping-pong channel swaps on the active channel's count
    if (!ping || grst1)
      st_next.active_channel_flag = 1'b0;
    else if (act_tc)
      st_next.active_channel_flag =
        ~st_reg.active_channel_flag;
    // Acknowledge: set by transfers, dropped by next request
    if (rq1 || grst1)
      st_next.acknowledge_out_g1 = 1'b0;
    else if (wide && (acc1 || acc2) && !st_next.data_ready_g1 &&
             !st_next.data_ready_g2)
      st_next.acknowledge_out_g1 = 1'b1;
    else if (!wide && acc1)
      st_next.acknowledge_out_g1 = 1'b1;
    if (wide || request_in_g2_edge || grst2)
      st_next.acknowledge_out_g2 = 1'b0;
    else if (acc2)
      st_next.acknowledge_out_g2 = 1'b1;
    // Both resets restart the pairing from empty
    if (grst1 && grst2) begin
      st_next.data_ready_g1      = 1'b0;
      st_next.data_ready_g2      = 1'b0;
      st_next.acknowledge_out_g1 = 1'b0;
    end
  end

  // Interrupt and DMA request next values
  logic irq1_next;
  logic irq2_next;
  logic src_rdy;
  logic dreq1_next;
  logic dreq2_next;

  assign irq1_next =
    (config_reg_one_reg.ready_irq_enable & st_next.data_ready_g1) |
    (mode_reg.termcount_irq_enable_g1 &
     st_next.termcount_flag_g1);
  assign irq2_next =
    (config_reg_two_reg.ready_irq_enable & st_next.data_ready_g2) |
    (mode_reg.termcount_irq_enable_g2 &
     st_next.termcount_flag_g2) |
    (mode_reg.timer_irq_enable & st_next.timer_irq_flag);
  // Wide mode feeds both words through channel one, or through the active channel when ping-pong is on
  assign src_rdy = wide ?
    (st_next.data_ready_g1 | st_next.data_ready_g2) :
    st_next.data_ready_g1;
  assign dreq1_next = config_reg_one_reg.dreq_enable & src_rdy &
    ~(ping & st_next.active_channel_flag);
  assign dreq2_next = ping ?
    (config_reg_two_reg.dreq_enable & src_rdy &
     st_next.active_channel_flag) :
    (~wide & config_reg_two_reg.dreq_enable &
     st_next.data_ready_g2);

  logic irq1_reg;
  logic irq2_reg;
  logic dreq1_reg;
  logic dreq2_reg;

  // Status, lines and input latch
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      st_reg       <= '0;
      irq1_reg     <= 1'b0;
      irq2_reg     <= 1'b0;
      dreq1_reg    <= 1'b0;
      dreq2_reg    <= 1'b0;
      in_latch_reg <= '0;
    end else begin
      st_reg    <= st_next;
      irq1_reg  <= irq1_next;
      irq2_reg  <= irq2_next;
      dreq1_reg <= dreq1_next;
      dreq2_reg <= dreq2_next;
      if (rq1)
        in_latch_reg[15:0] <= pin_s2_reg[20:5];
      if (rq2)
        in_latch_reg[31:16] <= pin_s2_reg[36:21];
    end
  end

  ////////////////////////////////////////////////////////////
  // Read channel
  logic [31:0] rd_mux;
  logic        rd_known;

  // Read data select
  always_comb begin
    rd_mux   = '0;
    rd_known = 1'b1;
    if (hit(i_araddr, `CONFIG_REG_ONE_OFF))
      rd_mux[1:0] = config_reg_one_reg;
    else if (hit(i_araddr, `CONFIG_REG_TWO_OFF))
      rd_mux[1:0] = config_reg_two_reg;
    else if (hit(i_araddr, `CONFIG_REG_THREE_OFF))
      rd_mux[4:0] = mode_reg;
    else if (hit(i_araddr, `STAT_OFF))
      rd_mux[7:0] = st_reg;
    else if (hit(i_araddr, `DATA1_OFF))
      rd_mux[15:0] = in_latch_reg[15:0];
    else if (hit(i_araddr, `DATA2_OFF))
      rd_mux[15:0] = in_latch_reg[31:16];
    else if (!(hit(i_araddr, `TCCLR1_OFF) ||
               hit(i_araddr, `TCCLR2_OFF) ||
               hit(i_araddr, `TMRCLR_OFF)))
      rd_known = 1'b0;
  end

  // One read at a time
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      ar_rdy_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg  <= '0;
      rresp_reg  <= `RESP_OKAY;
    end else if (ar_hs) begin
      ar_rdy_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_mux;
      rresp_reg  <= rd_known ? `RESP_OKAY : `RESP_SERR;
    end else if (r_hs) begin
      ar_rdy_reg <= 1'b1;
      rvalid_reg <= 1'b0;
    end
  end

  // Outputs straight from flip-flops
  assign o_awready            = aw_rdy_reg;
  assign o_wready             = w_rdy_reg;
  assign o_bvalid             = bvalid_reg;
  assign o_bresp              = bresp_reg;
  assign o_arready            = ar_rdy_reg;
  assign o_rvalid             = rvalid_reg;
  assign o_rdata              = rdata_reg;
  assign o_rresp              = rresp_reg;
  assign o_port_out           = {out2_reg, out1_reg};
  assign o_acknowledge_out_g1 = st_reg.acknowledge_out_g1;
  assign o_acknowledge_out_g2 = st_reg.acknowledge_out_g2;
  assign o_dreq_g1            = dreq1_reg;
  assign o_dreq_g2            = dreq2_reg;
  assign o_irq_g1             = irq1_reg;
  assign o_irq_g2             = irq2_reg;

  ////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);

  sequence wide_req_s;
    wide && request_in_g1_edge && !(grst1 && grst2);
  endsequence

  sequence both_taken_s;
    wide && (acc1 || acc2) && !rq1 && !grst1 &&
      !st_next.data_ready_g1 && !st_next.data_ready_g2;
  endsequence

  ready_irq_one_a: assert property (
    request_in_g1_edge && config_reg_one_reg.ready_irq_enable && !wr_config_reg_one
    |=> o_irq_g1 && st_reg.data_ready_g1)
    else $error("group one ready did not raise interrupt");

  access_clear_a: assert property (
    rd_data2 && !rq2 |=> !st_reg.data_ready_g2)
    else $error("read did not clear group two ready");

  tc_clear_a: assert property (
    wr_tcclr1 && !tc1_edge |=> !st_reg.termcount_flag_g1
    ##1 !o_irq_g1 || st_reg.data_ready_g1 ||
        st_reg.termcount_flag_g1)
    else $error("terminal count clear failed");

  timer_line_a: assert property (
    tmr_edge && mode_reg.timer_irq_enable && !wr_config_reg_three
    |=> st_reg.timer_irq_flag && o_irq_g2)
    else $error("timer event missed group two line");

  dreq_follow_a: assert property (
    !ping && !wide && config_reg_two_reg.dreq_enable &&
    st_reg.data_ready_g2 && $stable(config_reg_two_reg) && $stable(mode_reg)
    |-> o_dreq_g2 == $past(st_next.data_ready_g2) ||
        $past(wr_config_reg_two) || $past(wr_config_reg_three))
    else $error("group two request mismatch");

  channel_swap_a: assert property (
    ping && !wr_config_reg_three && !grst1 && act_tc
    |=> st_reg.active_channel_flag != $past(st_reg.active_channel_flag))
    else $error("channel did not swap on terminal count");

  wide_both_a: assert property (
    wide_req_s |=> st_reg.data_ready_g1 && st_reg.data_ready_g2)
    else $error("wide request did not set both ready flags");

  wide_ack_a: assert property (
    both_taken_s |=> o_acknowledge_out_g1 ##0 !o_acknowledge_out_g2)
    else $error("wide acknowledge missing after both words");

  wide_nack_a: assert property (
    wide && st_reg.data_ready_g2 && !acc2 && !grst2
    |=> !($rose(o_acknowledge_out_g1)))
    else $error("wide acknowledge before upper word");

  wide_restart_a: assert property (
    (grst1 || grst2) && !rq1 && !rq2
    |=> (!$past(grst1) || (!st_reg.data_ready_g1 && !o_acknowledge_out_g1)) &&
        (!$past(grst2) || (!st_reg.data_ready_g2 && !o_acknowledge_out_g2)))
    else $error("group resets did not restart pairing");

endmodule : handshake_irq_dma_sequencer

`default_nettype wire

// ==== sim/hsdma_far_end.sv ====
// Far-end model: handshaking device and host DMA controller.
// Assumes the bench times requests; one transfer count per channel.
`timescale 1ns/100ps
`default_nettype none
module hsdma_far_end #(
  parameter logic [15:0] TC_START = 16'h0001
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_nrst,
  input  wire logic [1:0]  i_kick,
  input  wire logic [31:0] i_data,
  input  wire logic [1:0]  i_dreq,
  output logic [1:0]       o_req,
  output logic [31:0]      o_port,
  output logic [1:0]       o_tc
);
  logic [15:0] cnt_reg [2];
  logic [1:0]  dreq_reg;
  wire  [1:0]  done = dreq_reg & ~i_dreq;
  // Device drives request and data lines as commanded
  assign o_req  = i_kick;
  assign o_port = i_data;
  // A finished request counts down; wrap from 0000 signals terminal count, then reload
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_reg  <= '{TC_START, TC_START};
      dreq_reg <= 2'h0;
      o_tc     <= 2'h0;
    end else begin
      dreq_reg <= i_dreq;
      for (int c = 0; c < 2; c++) begin
        o_tc[c] <= done[c] && cnt_reg[c] == 16'h0000;
        if (done[c]) begin
          cnt_reg[c] <= (cnt_reg[c] == 16'h0000) ? TC_START : cnt_reg[c] - 16'h0001;
        end
      end
    end
  end
endmodule : hsdma_far_end
`default_nettype wire

// ==== sim/handshake_irq_dma_sequencer_tb_top.sv ====
// Testbench of the interrupt and DMA request sequencer.
// Assumes the far-end model and the register map header.
`include "hsdma_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module handshake_irq_dma_sequencer_tb_top;
  logic        i_clk_sys, i_nrst, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_timer_out;
  logic [7:0]  i_awaddr, i_araddr;
  logic [31:0] i_wdata, pdata, rd;
  logic [3:0]  i_wstrb;
  logic [1:0]  kick, rs;
  wire  [31:0] o_rdata, o_port_out, i_port_in;
  wire  [1:0]  o_bresp, o_rresp;
  wire         o_awready, o_wready, o_bvalid, o_arready, o_rvalid, i_request_in_g1, i_request_in_g2;
  wire         o_acknowledge_out_g1, o_acknowledge_out_g2, i_dma_tc_g1, i_dma_tc_g2;
  wire         o_dreq_g1, o_dreq_g2, o_irq_g1, o_irq_g2;
  int          err_count, check_count;
  handshake_irq_dma_sequencer i_handshake_irq_dma_sequencer (
    .i_clk_sys, .i_nrst, .i_awvalid, .o_awready, .i_awaddr, .i_wvalid, .o_wready, .i_wdata, .i_wstrb,
    .o_bvalid, .i_bready, .o_bresp, .i_arvalid, .o_arready, .i_araddr, .o_rvalid, .i_rready, .o_rdata,
    .o_rresp, .i_request_in_g1, .i_request_in_g2, .i_port_in, .o_port_out, .o_acknowledge_out_g1,
    .o_acknowledge_out_g2, .i_timer_out, .i_dma_tc_g1, .i_dma_tc_g2, .o_dreq_g1, .o_dreq_g2, .o_irq_g1,
    .o_irq_g2);
  hsdma_far_end i_hsdma_far_end (.i_clk_sys, .i_nrst, .i_kick(kick), .i_data(pdata),
    .i_dreq({o_dreq_g2, o_dreq_g1}), .o_req({i_request_in_g2, i_request_in_g1}), .o_port(i_port_in),
    .o_tc({i_dma_tc_g2, i_dma_tc_g1}));
  ////////////////////////////////////////////////////////////
  // Verdict, comparison and bus tasks
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic bus_end(input int n);
    if (n == 50) begin
      err_count++;
      give_verdict();
    end else begin
      repeat (2) @(posedge i_clk_sys);
    end
  endtask : bus_end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge i_clk_sys);
    {i_awaddr, i_wdata} <= {a, d};
    {i_awvalid, i_wvalid, i_bready} <= 3'h7;
    for (n = 0; n < 50 && (i_awvalid || i_wvalid || !o_bvalid); n++) begin
      @(posedge i_clk_sys);
      if (o_awready) i_awvalid <= 1'h0;
      if (o_wready) i_wvalid <= 1'h0;
    end
    rs = o_bresp;
    i_bready <= 1'h0;
    bus_end(n);
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    int n;
    @(posedge i_clk_sys);
    i_araddr <= a;
    {i_arvalid, i_rready} <= 2'h3;
    for (n = 0; n < 50 && (i_arvalid || !o_rvalid); n++) begin
      @(posedge i_clk_sys);
      if (o_arready) i_arvalid <= 1'h0;
    end
    {rs, rd} = {o_rresp, o_rdata};
    i_rready <= 1'h0;
    bus_end(n);
  endtask : rdr
  // Request and timer pins pulse for three cycles, then settle
  task automatic pins(input logic [1:0] m, input logic t, input logic [31:0] d);
    @(posedge i_clk_sys);
    {kick, i_timer_out, pdata} <= {m, t, d};
    repeat (3) @(posedge i_clk_sys);
    {kick, i_timer_out} <= 3'h0;
    repeat (8) @(posedge i_clk_sys);
  endtask : pins
  task automatic rst;
    @(posedge i_clk_sys);
    i_nrst <= 1'h0;
    repeat (4) @(posedge i_clk_sys);
    i_nrst <= 1'h1;
  endtask : rst
  ////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_bus;
    rst();
    rdr(`CONFIG_REG_THREE_OFF);
    chk("config_reg_three reset", rd, 32'h0);
    wr(`CONFIG_REG_ONE_OFF, 32'h7);
    rdr(`CONFIG_REG_ONE_OFF);
    chk("config_reg_one", rd, 32'h3);
    rdr(8'h40);
    chk("unmapped rd", {rs, rd[29:0]}, 32'h8000_0000);
    wr(8'h44, 32'h1);
    chk("unmapped wr", rs, `RESP_SERR);
    $display("test bus done");
  endtask : t_bus
  task automatic t_ready;
    for (int g = 0; g < 2; g++) begin
      rst();
      wr(g ? `CONFIG_REG_TWO_OFF : `CONFIG_REG_ONE_OFF, 32'h1);
      for (int r = 0; r < 2; r++) begin
        pins(2'h1 << g, 1'h0, 32'h5a5a_c3c3 + r);
        rdr(`STAT_OFF);
        chk("ready", rd[g], 1'h1);
        chk("irq", g ? o_irq_g2 : o_irq_g1, 1'h1);
        rdr(g ? `DATA2_OFF : `DATA1_OFF);
        chk("data", rd, g ? 32'h5a5a : 32'hc3c3 + r);
        rdr(`STAT_OFF);
        chk("ready clr", {rd[1:0], o_irq_g2, o_irq_g1}, 4'h0);
      end
    end
    $display("test ready done");
  endtask : t_ready
  task automatic t_dreq;
    rst();
    wr(`CONFIG_REG_ONE_OFF, 32'h2);
    wr(`CONFIG_REG_TWO_OFF, 32'h1);
    pins(2'h3, 1'h0, 32'h1234_abcd);
    chk("dreq", {o_irq_g2, o_dreq_g2, o_dreq_g1, o_irq_g1}, 4'ha);
    wr(`DATA1_OFF, 32'hbeef);
    chk("dreq off", {o_dreq_g1, o_port_out[15:0]}, 17'hbeef);
    $display("test dreq done");
  endtask : t_dreq
  task automatic t_tc;
    rst();
    wr(`CONFIG_REG_THREE_OFF, 32'h3);
    wr(`CONFIG_REG_ONE_OFF, 32'h2);
    wr(`CONFIG_REG_TWO_OFF, 32'h2);
    repeat (2) begin
      pins(2'h3, 1'h0, 32'h0);
      rdr(`DATA1_OFF);
      rdr(`DATA2_OFF);
    end
    pins(2'h0, 1'h0, 32'h0);
    rdr(`STAT_OFF);
    chk("tc set", {rd[3:2], o_irq_g2, o_irq_g1}, 4'hf);
    wr(`TCCLR1_OFF, 32'h0);
    rdr(`STAT_OFF);
    chk("tc1 clr", {rd[3:2], o_irq_g2, o_irq_g1}, 4'ha);
    wr(`TCCLR2_OFF, 32'hffff_ffff);
    rdr(`STAT_OFF);
    chk("tc2 clr", {rd[3:2], o_irq_g2, o_irq_g1}, 4'h0);
    $display("test termcount done");
  endtask : t_tc
  task automatic t_timer;
    rst();
    pins(2'h0, 1'h1, 32'h0);
    rdr(`STAT_OFF);
    chk("tmr off", rd[4], 1'h0);
    wr(`CONFIG_REG_THREE_OFF, 32'h4);
    pins(2'h0, 1'h1, 32'h0);
    rdr(`STAT_OFF);
    chk("tmr", {rd[4], o_irq_g2, o_irq_g1}, 3'h6);
    wr(`TMRCLR_OFF, 32'h0);
    rdr(`STAT_OFF);
    chk("tmr clr", {rd[4], o_irq_g2}, 2'h0);
    $display("test timer done");
  endtask : t_timer
  task automatic t_ping;
    rst();
    wr(`CONFIG_REG_THREE_OFF, 32'h8);
    wr(`CONFIG_REG_ONE_OFF, 32'h2);
    wr(`CONFIG_REG_TWO_OFF, 32'h2);
    for (int r = 0; r < 5; r++) begin
      pins(2'h1, 1'h0, 32'h0);
      rdr(`STAT_OFF);
      chk("channel", {rd[5], o_dreq_g2, o_dreq_g1}, ((r / 2) % 2) ? 3'h6 : 3'h1);
      rdr(`DATA1_OFF);
      pins(2'h0, 1'h0, 32'h0);
    end
    $display("test pingpong done");
  endtask : t_ping
  task automatic t_wide;
    rst();
    wr(`CONFIG_REG_THREE_OFF, 32'h10);
    wr(`CONFIG_REG_ONE_OFF, 32'h2);
    wr(`CONFIG_REG_TWO_OFF, 32'h2);
    pins(2'h2, 1'h0, 32'h0);
    rdr(`STAT_OFF);
    chk("g2 ignored", rd[1:0], 2'h0);
    pins(2'h1, 1'h0, 32'h8765_4321);
    rdr(`STAT_OFF);
    chk("both ready", {rd[1:0], o_dreq_g2, o_dreq_g1}, 4'hd);
    rdr(`DATA1_OFF);
    chk("low word", {rd[15:0], o_acknowledge_out_g1, o_dreq_g1}, 18'h10c85);
    rdr(`DATA2_OFF);
    chk("high word", {rd[15:0], o_acknowledge_out_g2, o_acknowledge_out_g1, o_dreq_g1}, 19'h4_3b2a);
    pins(2'h1, 1'h0, 32'h0);
    rdr(`DATA1_OFF);
    wr(`CONFIG_REG_ONE_OFF, 32'h6);
    wr(`CONFIG_REG_TWO_OFF, 32'h6);
    rdr(`STAT_OFF);
    chk("restart", {rd[1:0], o_acknowledge_out_g1}, 3'h0);
    $display("test wide done");
  endtask : t_wide
  ////////////////////////////////////////////////////////////
  // Clock and main sequence
  initial begin
    i_clk_sys = 1'h0;
    forever #20 i_clk_sys = ~i_clk_sys;
  end
  initial begin
    {i_nrst, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_timer_out, kick} = 9'h0;
    {i_awaddr, i_araddr, i_wdata, pdata} = 80'h0;
    i_wstrb = 4'hf;
    {err_count, check_count} = 64'h0;
    t_bus();
    t_ready();
    t_dreq();
    t_tc();
    t_timer();
    t_ping();
    t_wide();
    give_verdict();
  end
endmodule : handshake_irq_dma_sequencer_tb_top
`default_nettype wire
